// ===== bench/csa_unit_monitor.sv
// Checker of the port timing of the compressed stack unit.
`timescale 1ns/1ps
`default_nettype none
module csa_unit_monitor (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_INSTR_VALID,
  input wire logic [15:0] I_INSTR,
  input wire logic [31:0] I_INSTR_ADDR,
  input wire logic [31:0] I_SP,
  input wire logic [3:0] I_FLAGS,
  input wire logic I_MEM_ACK,
  input wire logic O_BUSY,
  input wire logic O_DONE,
  input wire logic O_REG_WE,
  input wire logic [31:0] O_REG_WDATA,
  input wire logic O_SP_WE,
  input wire logic [31:0] O_SP_WDATA,
  input wire logic [3:0] O_FLAGS,
  input wire logic O_MEM_REQ,
  input wire logic O_MEM_WR,
  input wire logic [31:0] O_MEM_ADDR
);
  import csa_pkg::*;
  // ***************************************************************************
  // Helper state
  // ***************************************************************************
  logic take_w;
  logic ldst_r;
  logic [15:0] ins_r;
  logic [31:0] iaddr_r;
  logic [31:0] sp_r;
  logic [31:0] imm_w;
  logic [31:0] mag_w;
  // An offer is taken while the unit is idle or shows its completion; immediates come
  // from the held word.
  assign take_w = I_INSTR_VALID && (!O_BUSY || O_DONE);
  assign imm_w = {22'h0, ins_r[7:0], 2'h0};
  assign mag_w = {23'h0, ins_r[6:0], 2'h0};
  // Hold the operands of the last taken instruction.
  always_ff @(posedge I_REF_CLK) begin
    if (take_w) begin
      ins_r <= I_INSTR;
      iaddr_r <= I_INSTR_ADDR;
      sp_r <= I_SP;
    end
  end
  // Mark a single load or store as in flight until it finishes.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      ldst_r <= 1'h0;
    end else if (take_w) begin
      ldst_r <= I_INSTR[15:12] == GRP_SP_LDST;
    end else if (O_DONE) begin
      ldst_r <= 1'h0;
    end
  end
  // ***************************************************************************
  // Properties
  // ***************************************************************************
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (!I_RST_N);
  sequence s_take_pc;
    take_w && I_INSTR[15:12] == GRP_LD_ADDR && !I_INSTR[POS_LOAD];
  endsequence
  sequence s_take_sp;
    take_w && I_INSTR[15:12] == GRP_LD_ADDR && I_INSTR[POS_LOAD];
  endsequence
  sequence s_take_adj;
    take_w && I_INSTR[15:8] == GRP_SP_ADJ;
  endsequence
  sequence s_alu_end;
    O_DONE && (O_REG_WE || O_SP_WE);
  endsequence
  a_alu_latency: assert property (
    take_w && (I_INSTR[15:12] == GRP_LD_ADDR || I_INSTR[15:8] == GRP_SP_ADJ) |-> ##2 s_alu_end)
    else $error("Short instruction did not end two cycles after it was taken.");
  a_pc_value: assert property (
    s_take_pc |-> ##2 O_REG_WE && O_REG_WDATA == ((iaddr_r + PC_AHEAD) & 32'hFFFF_FFFD) + imm_w)
    else $error("PC-relative address sum is wrong.");
  a_sp_value: assert property (
    s_take_sp |-> ##2 O_REG_WE && O_REG_WDATA == sp_r + imm_w)
    else $error("SP-relative address sum is wrong.");
  a_sp_adjust: assert property (
    s_take_adj |-> ##2 O_SP_WE && O_SP_WDATA == (ins_r[POS_SIGN] ? sp_r - mag_w : sp_r + mag_w))
    else $error("Stack adjust result is wrong.");
  a_ldst_addr: assert property (
    ldst_r && O_MEM_REQ |-> O_MEM_ADDR == sp_r + imm_w && O_MEM_WR == !ins_r[POS_LOAD])
    else $error("Single transfer address or direction is wrong.");
  a_req_hold: assert property (
    O_MEM_REQ && !I_MEM_ACK |=> O_MEM_REQ && $stable(O_MEM_ADDR) && $stable(O_MEM_WR))
    else $error("Memory request changed before it was acknowledged.");
  a_req_drop: assert property (
    O_MEM_REQ && I_MEM_ACK |=> !O_MEM_REQ)
    else $error("Memory request stayed up after its acknowledge.");
  a_flags_echo: assert property (
    $past(I_RST_N) |-> O_FLAGS == $past(I_FLAGS))
    else $error("Status flags were altered.");
  a_done_pulse: assert property (
    O_DONE |=> !O_DONE)
    else $error("Done lasted more than one cycle.");
endmodule : csa_unit_monitor
`default_nettype wire

// ===== bench/csa_unit_tb.sv
// Self-checking bench of the compressed stack unit.
`timescale 1ns/1ps
`default_nettype none
bind csa_unit csa_unit_monitor u_mon (.I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N),
  .I_INSTR_VALID(I_INSTR_VALID), .I_INSTR(I_INSTR), .I_INSTR_ADDR(I_INSTR_ADDR), .I_SP(I_SP),
  .I_FLAGS(I_FLAGS), .I_MEM_ACK(I_MEM_ACK), .O_BUSY(O_BUSY), .O_DONE(O_DONE),
  .O_REG_WE(O_REG_WE), .O_REG_WDATA(O_REG_WDATA), .O_SP_WE(O_SP_WE), .O_SP_WDATA(O_SP_WDATA),
  .O_FLAGS(O_FLAGS), .O_MEM_REQ(O_MEM_REQ), .O_MEM_WR(O_MEM_WR), .O_MEM_ADDR(O_MEM_ADDR));
module csa_unit_tb;
  import csa_pkg::*;
  logic clk, rst_n, valid, ack;
  logic [15:0] instr;
  logic [31:0] iaddr, sp, lr, rd_data;
  logic [31:0] regs [NUM_LOW_REGS];
  logic [3:0] flags;
  wire logic busy, done, decoded, reg_we, sp_we, branch, mem_req, mem_wr;
  wire logic [3:0] reg_idx, flags_o;
  wire logic [31:0] rdata, reg_wdata, sp_wdata, br_addr, mem_addr, mem_wdata;
  logic [64:0] mq[$], em[$];
  logic [35:0] rq[$], er[$];
  logic [31:0] sq[$], es[$], bq[$], eb[$];
  logic [15:0] corners [11] = '{16'h97FF, 16'h9800, 16'hA7FF, 16'hAFFF, 16'hB07F, 16'hB0FF,
    16'hB5FF, 16'hB4FF, 16'hBD00, 16'hBC00, 16'hBDFF};
  int num_errors = 0;
  int compares = 0;
  // Memory contents seen by loads, a fixed function of the address.
  function automatic logic [31:0] mf(input logic [31:0] a);
    mf = ({a[15:0], a[31:16]} ^ 32'h3C5A_96A4) & 32'hFFFF_FFFC;
  endfunction : mf
  // Read data is only meaningful while acknowledged.
  assign rdata = ack ? mf(mem_addr) : ~mf(mem_addr);
  csa_unit uut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_INSTR_VALID(valid), .I_INSTR(instr),
    .I_INSTR_ADDR(iaddr), .I_SP(sp), .I_LR(lr), .I_RD_DATA(rd_data), .I_REG_LIST_DATA(regs),
    .I_FLAGS(flags), .I_MEM_ACK(ack), .I_MEM_RDATA(rdata), .O_BUSY(busy), .O_DONE(done),
    .O_DECODED(decoded), .O_REG_WE(reg_we), .O_REG_IDX(reg_idx), .O_REG_WDATA(reg_wdata),
    .O_SP_WE(sp_we), .O_SP_WDATA(sp_wdata), .O_BRANCH(branch), .O_BRANCH_ADDR(br_addr),
    .O_FLAGS(flags_o), .O_MEM_REQ(mem_req), .O_MEM_WR(mem_wr), .O_MEM_ADDR(mem_addr),
    .O_MEM_WDATA(mem_wdata));
  // Free-running 40 MHz clock.
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  // Acknowledge a held memory request after a random stall.
  always @(posedge clk) begin
    #1 ack = mem_req === 1'h1 && !ack && $urandom_range(2) == 0;
  end
  // Record every transfer, register write, SP write and branch.
  always @(posedge clk) begin
    if (ack && mem_req) mq.push_back({mem_wr, mem_addr, mem_wr ? mem_wdata : 32'h0});
    if (reg_we) rq.push_back({reg_idx, reg_wdata});
    if (sp_we) sq.push_back(sp_wdata);
    if (branch) bq.push_back(br_addr);
  end
  // Compare a seen value with the predicted one.
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Print the counts and the verdict, then stop.
  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  // Draw one instruction of a random group.
  function automatic logic [15:0] rnd();
    logic [15:0] r;
    r = 16'($urandom);
    case (r[15:14])
      2'h0: rnd = {GRP_SP_LDST, r[11:0]};
      2'h1: rnd = {GRP_LD_ADDR, r[11:0]};
      2'h2: rnd = {GRP_SP_ADJ, r[7:0]};
      default: rnd = {GRP_PUSHPOP_HI, r[11], GRP_PUSHPOP_MID, r[8:0]};
    endcase
  endfunction : rnd
  // Issue one instruction with random operands, predict its effects, compare.
  task automatic run(input logic [15:0] ins);
    int n;
    int k;
    logic [31:0] a;
    sp = $urandom & 32'hFFFF_FFFC;
    lr = $urandom;
    rd_data = $urandom;
    iaddr = $urandom & 32'hFFFF_FFFE;
    flags = 4'($urandom);
    foreach (regs[i]) regs[i] = $urandom;
    em.delete(); er.delete(); es.delete(); eb.delete();
    if (ins[15:12] == GRP_SP_LDST) begin
      a = sp + {22'h0, ins[7:0], 2'h0};
      em.push_back({!ins[POS_LOAD], a, ins[POS_LOAD] ? 32'h0 : rd_data});
      if (ins[POS_LOAD]) er.push_back({1'h0, ins[10:8], mf(a)});
    end else if (ins[15:12] == GRP_LD_ADDR) begin
      a = ins[POS_LOAD] ? sp : (iaddr + PC_AHEAD) & 32'hFFFF_FFFD;
      er.push_back({1'h0, ins[10:8], a + {22'h0, ins[7:0], 2'h0}});
    end else if (ins[15:8] == GRP_SP_ADJ) begin
      a = {23'h0, ins[6:0], 2'h0};
      es.push_back(ins[POS_SIGN] ? sp - a : sp + a);
    end else begin
      n = $countones(ins[8:0]);
      a = ins[POS_LOAD] ? sp : sp - 32'(4 * n);
      for (k = 0; k < 9; k++) begin
        if (ins[k]) begin
          if (!ins[POS_LOAD]) em.push_back({1'h1, a, k < 8 ? regs[k[2:0]] : lr});
          else em.push_back({1'h0, a, 32'h0});
          if (ins[POS_LOAD] && k < 8) er.push_back({4'(k), mf(a)});
          if (ins[POS_LOAD] && k == 8) eb.push_back(mf(a));
          a = a + WORD_BYTES;
        end
      end
      es.push_back(ins[POS_LOAD] ? a : sp - 32'(4 * n));
    end
    mq.delete(); rq.delete(); sq.delete(); bq.delete();
    valid = 1'h1;
    instr = ins;
    @(posedge clk);
    #1 valid = 1'h0;
    chk(80'({decoded, busy}), 80'h3);
    k = 0;
    while (done !== 1'h1 && k < 300) begin
      @(posedge clk);
      #1 k++;
    end
    if (k == 300) chk(80'h1, 80'h0);
    @(posedge clk);
    #1 chk(80'(mq.size()), 80'(em.size()));
    foreach (em[i]) chk(80'(mq[i]), 80'(em[i]));
    chk(80'(rq.size()), 80'(er.size()));
    foreach (er[i]) chk(80'(rq[i]), 80'(er[i]));
    chk(80'(sq.size()), 80'(es.size()));
    foreach (es[i]) chk(80'(sq[i]), 80'(es[i]));
    chk(80'(bq.size()), 80'(eb.size()));
    foreach (eb[i]) chk(80'(bq[i]), 80'(eb[i]));
    chk(80'(flags_o), 80'(flags));
  endtask : run
  // Reset, corner cases, random traffic, then an undecodable offer.
  initial begin
    void'($urandom(54));
    valid = 1'h0;
    instr = 16'h0;
    {iaddr, sp, lr, rd_data, flags, ack} = '0;
    foreach (regs[i]) regs[i] = 32'h0;
    rst_n = 1'h0;
    repeat (3) @(posedge clk);
    #1 rst_n = 1'h1;
    chk(80'({busy, done, reg_we, sp_we, mem_req}), 80'h0);
    foreach (corners[i]) run(corners[i]);
    repeat (80) run(rnd());
    valid = 1'h1;
    instr = 16'hB100;
    @(posedge clk);
    #1 valid = 1'h0;
    repeat (5) begin
      @(posedge clk);
      #1 chk(80'(decoded | busy), 80'h0);
    end
    tally_and_finish();
  end
  // Cut a hang short well beyond the expected run length.
  initial begin
    #(25 * 40000);
    num_errors++;
    tally_and_finish();
  end
endmodule : csa_unit_tb
`default_nettype wire

// ===== hdl/csa_pkg.sv
// Package with the encodings, field positions and timing counts of the compressed stack unit.
package csa_pkg;
  // ***************************************************************************
  // Opcode field positions and group patterns
  // ***************************************************************************
  localparam logic [3:0] GRP_SP_LDST = 4'h9;   // Bits 15:12 = 1001.
  localparam logic [3:0] GRP_LD_ADDR = 4'hA;   // Bits 15:12 = 1010.
  localparam logic [7:0] GRP_SP_ADJ = 8'hB0;   // Bits 15:8 = 1011_0000.
  localparam logic [3:0] GRP_PUSHPOP_HI = 4'hB;
  localparam logic [1:0] GRP_PUSHPOP_MID = 2'h2; // Bits 10:9 = 10.
  localparam int POS_LOAD = 11;
  localparam int POS_RD_LO = 8;
  localparam int POS_EXTRA = 8;
  localparam int POS_SIGN = 7;
  localparam int WORD_SHIFT = 2;
  localparam int NUM_LOW_REGS = 8;
  localparam logic [31:0] PC_AHEAD = 32'h0000_0004;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [3:0] REG_LR = 4'hE;
  localparam logic [3:0] REG_PC = 4'hF;
  localparam logic [3:0] REG_SP = 4'hD;
  // ***************************************************************************
  // Cycle counts, matching the full-width equivalents
  // ***************************************************************************
  localparam logic [4:0] CYC_ALU = 5'h01;     // Address forms and stack adjust.
  localparam logic [4:0] CYC_STORE = 5'h02;   // Single store.
  localparam logic [4:0] CYC_LOAD = 5'h03;    // Single load.
  localparam logic [4:0] CYC_PC_REFILL = 5'h02; // Extra cycles after a PC load.
  // ***************************************************************************
  // Sequencer states
  // ***************************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_EXEC = 3'b001,
    ST_XFER = 3'b010,
    ST_WBACK = 3'b011,
    ST_WAIT = 3'b100
  } csa_state_t;
endpackage : csa_pkg

// ===== hdl/csa_unit.sv
// Execute unit for SP-relative transfers, address forms, stack adjust and push/pop.
`timescale 1ns/1ps
`default_nettype none
module csa_unit (
  input wire logic I_REF_CLK,
  input wire logic I_RST_N,
  input wire logic I_INSTR_VALID,
  input wire logic [15:0] I_INSTR,
  input wire logic [31:0] I_INSTR_ADDR,
  input wire logic [31:0] I_SP,
  input wire logic [31:0] I_LR,
  input wire logic [31:0] I_RD_DATA,
  input wire logic [31:0] I_REG_LIST_DATA [csa_pkg::NUM_LOW_REGS],
  input wire logic [3:0] I_FLAGS,
  input wire logic I_MEM_ACK,
  input wire logic [31:0] I_MEM_RDATA,
  output logic O_BUSY,
  output logic O_DONE,
  output logic O_DECODED,
  output logic O_REG_WE,
  output logic [3:0] O_REG_IDX,
  output logic [31:0] O_REG_WDATA,
  output logic O_SP_WE,
  output logic [31:0] O_SP_WDATA,
  output logic O_BRANCH,
  output logic [31:0] O_BRANCH_ADDR,
  output logic [3:0] O_FLAGS,
  output logic O_MEM_REQ,
  output logic O_MEM_WR,
  output logic [31:0] O_MEM_ADDR,
  output logic [31:0] O_MEM_WDATA
);
  import csa_pkg::*;
  csa_xfer_if xf ();
  csa_state_t state_r;
  logic [15:0] ins_r;
  logic [31:0] addr_r;
  logic [31:0] new_sp_r;
  logic [31:0] pc_r;
  logic [7:0] list_r;
  logic extra_r;
  logic load_r;
  logic single_r;
  logic [4:0] wait_r;
  logic [31:0] regs_r [NUM_LOW_REGS];
  logic [31:0] lr_r;
  logic [31:0] rd_data_r;
  // ***************************************************************************
  // Decode
  // ***************************************************************************
  logic is_ldst;
  logic is_addr;
  logic is_adj;
  logic is_pp;
  logic [31:0] imm_w;
  logic [31:0] adj_w;
  logic [31:0] pc_src;
  logic [3:0] cnt_w;
  assign is_ldst = I_INSTR[15:12] == GRP_SP_LDST;
  assign is_addr = I_INSTR[15:12] == GRP_LD_ADDR;
  assign is_adj = I_INSTR[15:8] == GRP_SP_ADJ;
  assign is_pp = (I_INSTR[15:12] == GRP_PUSHPOP_HI) && (I_INSTR[10:9] == GRP_PUSHPOP_MID);
  // Offset field in words becomes a word-aligned byte offset.
  assign imm_w = {22'h0, I_INSTR[7:0], 2'h0};
  // Seven-bit magnitude in words of the held instruction, at most 127 words or 508 bytes.
  assign adj_w = {23'h0, ins_r[6:0], 2'h0};
  // PC reads four bytes ahead with bit 1 cleared.
  assign pc_src = (I_INSTR_ADDR + PC_AHEAD) & ~32'h0000_0002;
  // Number of words moved by push or pop, low list plus the optional extra.
  always_comb begin
    cnt_w = {3'h0, I_INSTR[POS_EXTRA]};
    for (int i = 0; i < NUM_LOW_REGS; i++) begin
      cnt_w = cnt_w + {3'h0, I_INSTR[i]};
    end
  end
  // ***************************************************************************
  // Sequencer
  // ***************************************************************************
  logic [2:0] next_reg;
  logic list_empty;
  always_comb begin
    next_reg = 3'h0;
    for (int i = NUM_LOW_REGS - 1; i >= 0; i--) begin
      if (list_r[i]) begin
        next_reg = 3'(i);
      end
    end
  end
  assign list_empty = list_r == 8'h00;
  // Main state machine: one instruction at a time, transfers in ascending order.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      state_r <= ST_IDLE;
      ins_r <= 16'h0000;
      addr_r <= 32'h0000_0000;
      new_sp_r <= 32'h0000_0000;
      pc_r <= 32'h0000_0000;
      list_r <= 8'h00;
      extra_r <= 1'b0;
      load_r <= 1'b0;
      single_r <= 1'b0;
      wait_r <= 5'h00;
      lr_r <= 32'h0000_0000;
      rd_data_r <= 32'h0000_0000;
      xf.req <= 1'b0;
      xf.wr <= 1'b0;
      xf.addr <= 32'h0000_0000;
      xf.wdata <= 32'h0000_0000;
      xf.reg_idx <= 4'h0;
      for (int i = 0; i < NUM_LOW_REGS; i++) begin
        regs_r[i] <= 32'h0000_0000;
      end
    end else begin
      xf.req <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (I_INSTR_VALID && (is_ldst || is_addr || is_adj || is_pp)) begin
            ins_r <= I_INSTR;
            pc_r <= pc_src;
            load_r <= I_INSTR[POS_LOAD];
            lr_r <= I_LR;
            rd_data_r <= I_RD_DATA;
            for (int i = 0; i < NUM_LOW_REGS; i++) begin
              regs_r[i] <= I_REG_LIST_DATA[i];
            end
            wait_r <= CYC_ALU;
            state_r <= ST_EXEC;
            single_r <= is_ldst;
            list_r <= is_pp ? I_INSTR[7:0] : 8'h00;
            extra_r <= is_pp && I_INSTR[POS_EXTRA];
            if (is_ldst) begin
              addr_r <= I_SP + imm_w;
              new_sp_r <= I_SP;
            end else if (is_pp && !I_INSTR[POS_LOAD]) begin
              // Full descending: lowest word sits count words below SP.
              addr_r <= I_SP - {26'h0, cnt_w, 2'h0};
              new_sp_r <= I_SP - {26'h0, cnt_w, 2'h0};
            end else if (is_pp) begin
              addr_r <= I_SP;
              new_sp_r <= I_SP + {26'h0, cnt_w, 2'h0};
            end else begin
              // Address forms and stack adjust start from the unmodified SP.
              addr_r <= I_SP;
              new_sp_r <= I_SP;
            end
          end
        end
        ST_EXEC: begin
          if (single_r) begin
            xf.req <= 1'b1;
            xf.wr <= !load_r;
            xf.addr <= addr_r;
            xf.wdata <= rd_data_r;
            xf.reg_idx <= {1'b0, ins_r[10:8]};
            single_r <= 1'b0;
            state_r <= ST_XFER;
          end else if (ins_r[15:12] == GRP_PUSHPOP_HI && ins_r[10:9] == GRP_PUSHPOP_MID) begin
            state_r <= ST_XFER;
          end else if (wait_r > 5'h01) begin
            wait_r <= wait_r - 5'h01;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        ST_XFER: begin
          if (!xf.req && (xf.done || !ins_r[12] || ins_r[15:12] != GRP_SP_LDST)) begin
            if (ins_r[15:12] == GRP_SP_LDST) begin
              if (xf.done) begin
                state_r <= ST_WBACK;
              end
            end else if (!list_empty) begin
              // Lowest listed register first, at the lowest address.
              xf.req <= 1'b1;
              xf.wr <= !load_r;
              xf.addr <= addr_r;
              xf.wdata <= regs_r[next_reg];
              xf.reg_idx <= {1'b0, next_reg};
              list_r[next_reg] <= 1'b0;
              addr_r <= addr_r + WORD_BYTES;
              state_r <= ST_WAIT;
            end else if (extra_r) begin
              // The extra word takes the highest address.
              xf.req <= 1'b1;
              xf.wr <= !load_r;
              xf.addr <= addr_r;
              xf.wdata <= lr_r;
              xf.reg_idx <= load_r ? REG_PC : REG_LR;
              extra_r <= 1'b0;
              addr_r <= addr_r + WORD_BYTES;
              state_r <= ST_WAIT;
            end else begin
              state_r <= ST_WBACK;
            end
          end
        end
        ST_WAIT: begin
          if (xf.done) begin
            state_r <= ST_XFER;
          end
        end
        ST_WBACK: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
  // ***************************************************************************
  // Result outputs
  // ***************************************************************************
  // Register and SP writes, branch and completion flags, all registered.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_REG_WE <= 1'b0;
      O_REG_IDX <= 4'h0;
      O_REG_WDATA <= 32'h0000_0000;
      O_SP_WE <= 1'b0;
      O_SP_WDATA <= 32'h0000_0000;
      O_BRANCH <= 1'b0;
      O_BRANCH_ADDR <= 32'h0000_0000;
      O_DONE <= 1'b0;
    end else begin
      O_REG_WE <= 1'b0;
      O_SP_WE <= 1'b0;
      O_BRANCH <= 1'b0;
      O_DONE <= 1'b0;
      if (state_r == ST_EXEC && wait_r == 5'h01 && !single_r
          && ins_r[15:12] == GRP_LD_ADDR) begin
        O_REG_WE <= 1'b1;
        O_REG_IDX <= {1'b0, ins_r[10:8]};
        if (ins_r[POS_LOAD]) begin
          O_REG_WDATA <= new_sp_r + {22'h0, ins_r[7:0], 2'h0};
        end else begin
          O_REG_WDATA <= pc_r + {22'h0, ins_r[7:0], 2'h0};
        end
        O_DONE <= 1'b1;
      end
      if (state_r == ST_EXEC && wait_r == 5'h01 && ins_r[15:8] == GRP_SP_ADJ) begin
        O_SP_WE <= 1'b1;
        if (ins_r[POS_SIGN]) begin
          O_SP_WDATA <= new_sp_r - adj_w;
        end else begin
          O_SP_WDATA <= new_sp_r + adj_w;
        end
        O_DONE <= 1'b1;
      end
      // Loaded words go to the register file; a loaded PC becomes a branch.
      if (xf.done && load_r) begin
        if (xf.rd_idx == REG_PC) begin
          O_BRANCH <= 1'b1;
          O_BRANCH_ADDR <= xf.rdata;
        end else begin
          O_REG_WE <= 1'b1;
          O_REG_IDX <= xf.rd_idx;
          O_REG_WDATA <= xf.rdata;
        end
      end
      // SP is written back after the last transfer of a push or pop.
      if (state_r == ST_WBACK) begin
        O_DONE <= 1'b1;
        if (ins_r[15:12] == GRP_PUSHPOP_HI) begin
          O_SP_WE <= 1'b1;
          O_SP_WDATA <= new_sp_r;
        end
      end
    end
  end
  // Flags pass through untouched; none of these instructions sets them.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_FLAGS <= 4'h0;
    end else begin
      O_FLAGS <= I_FLAGS;
    end
  end
  // Busy and decode status.
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      O_BUSY <= 1'b0;
      O_DECODED <= 1'b0;
    end else begin
      O_BUSY <= (state_r != ST_IDLE) || (I_INSTR_VALID && (is_ldst || is_addr || is_adj || is_pp));
      O_DECODED <= state_r == ST_IDLE && I_INSTR_VALID && (is_ldst || is_addr || is_adj || is_pp);
    end
  end
  // ***************************************************************************
  // Memory transfer engine
  // ***************************************************************************
  csa_xfer_engine u_eng (
    .clk(I_REF_CLK),
    .rst_n(I_RST_N),
    .xf(xf.engine),
    .mem_req(O_MEM_REQ),
    .mem_wr(O_MEM_WR),
    .mem_addr(O_MEM_ADDR),
    .mem_wdata(O_MEM_WDATA),
    .mem_ack(I_MEM_ACK),
    .mem_rdata(I_MEM_RDATA)
  );
endmodule : csa_unit
`default_nettype wire

// ===== hdl/csa_xfer_engine.sv
// Memory transfer engine that drives the memory port and returns loaded words.
`timescale 1ns/1ps
`default_nettype none
module csa_xfer_engine (
  input wire logic clk,
  input wire logic rst_n,
  csa_xfer_if.engine xf,
  output logic mem_req,
  output logic mem_wr,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);
  import csa_pkg::*;
  logic busy_r;
  logic [3:0] idx_r;
  // ***************************************************************************
  // Request hold and completion
  // ***************************************************************************
  // One request is held on the memory port until the memory acknowledges it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      idx_r <= 4'h0;
      mem_req <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
    end else if (!busy_r && xf.req) begin
      busy_r <= 1'b1;
      idx_r <= xf.reg_idx;
      mem_req <= 1'b1;
      mem_wr <= xf.wr;
      mem_addr <= xf.addr;
      mem_wdata <= xf.wdata;
    end else if (busy_r && mem_ack) begin
      busy_r <= 1'b0;
      mem_req <= 1'b0;
    end
  end
  // Completion pulse with the loaded word and its destination register.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xf.done <= 1'b0;
      xf.rdata <= 32'h0000_0000;
      xf.rd_idx <= 4'h0;
    end else begin
      xf.done <= busy_r && mem_ack;
      if (busy_r && mem_ack) begin
        xf.rdata <= mem_rdata;
        xf.rd_idx <= idx_r;
      end
    end
  end
endmodule : csa_xfer_engine
`default_nettype wire

// ===== hdl/csa_xfer_if.sv
// Interface carrying one memory transfer request between the unit and its transfer engine.
`timescale 1ns/1ps
`default_nettype none
interface csa_xfer_if;
  logic req;
  logic wr;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [3:0] reg_idx;
  logic done;
  logic [31:0] rdata;
  logic [3:0] rd_idx;
  modport master (output req, output wr, output addr, output wdata, output reg_idx,
    input done, input rdata, input rd_idx);
  modport engine (input req, input wr, input addr, input wdata, input reg_idx,
    output done, output rdata, output rd_idx);
endinterface : csa_xfer_if
`default_nettype wire
